// file: rtl/io_pack_regs.svh
// Summary of operation
// R1 - decode io, id, interrupt selects and acknowledge
// R2 - hold vector, gate event interrupt by enable
// R3 - enable, software reset and vector registers here
// R4 - id space returns 32x8 read-only bytes
// R5 - all registers use an 8-bit data path
// R6 - io port data in least significant byte
// R7 - interrupt select returns the vector byte
// R8 - every cycle completes with zero wait states
// R9 - four debounce windows from 8 MHz tick
// R10 - debounce runs only with debounce clock enabled
// R11 - every input line has its own debounce
// R12 - per-channel event interrupts, rising or falling chosen per group of four
// R13 - enabled event pulls interrupt request low
// R14 - channels grouped into ports of eight
// R15 - 32 of 48 controller lines are used
// R16 - four unlock writes to port 7 enter enhanced
// R17 - enhanced port 7 writes pick bank from bits 7:6
// R18 - writing 1 arms, writing 0 clears event
// R19 - release request on flag clear or disable
// R20 - unimplemented spaces are ignored, never acknowledged
`ifndef IO_PACK_REGS_SVH
`define IO_PACK_REGS_SVH

// ----------------------------------------------------------------
// io space offsets
// ----------------------------------------------------------------
`define OFS_PORT0 6'h00
`define OFS_PORT1 6'h01
`define OFS_PORT3 6'h03
`define OFS_PORT6 6'h06
`define OFS_PORT7 6'h07
`define OFS_IVR 6'h08
`define OFS_IER 6'h09

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define IER_EN_BIT 0
`define IER_SRST_BIT 1
`define DBCLK_EN_BIT 0
`define BANK_LSB 6
`define BANK_STATE 2'h0
`define BANK_EVENT 2'h1
`define BANK_DEBOUNCE 2'h2
`define UNLOCK_B0 8'h07
`define UNLOCK_B1 8'h0D
`define UNLOCK_B2 8'h06
`define UNLOCK_B3 8'h12
`define ACK_IDLE 1'b1
`define IRQ_IDLE 1'b1
`define DB_STABLE 2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MCLK_PERIOD_PS 5000
`define SYS_CLK_PERIOD_PS 125000
`define DB_STEP0_NS 1000
`define DB_STEP1_NS 16000
`define DB_STEP2_NS 250000
`define DB_STEP3_NS 2000000

// ----------------------------------------------------------------
// identification bytes
// ----------------------------------------------------------------
`define ID_OFS_I 5'h00
`define ID_OFS_P 5'h01
`define ID_OFS_A 5'h02
`define ID_OFS_C 5'h03
`define ID_OFS_MAKER 5'h04
`define ID_OFS_MODEL 5'h05
`define ID_OFS_REV 5'h06
`define ID_OFS_USED 5'h0B
`define ID_ASCII_I 8'h49
`define ID_ASCII_P 8'h50
`define ID_ASCII_A 8'h41
`define ID_ASCII_C 8'h43
`define ID_USED_BYTES 8'h0C

`endif

// file: rtl/io_pack_pkg.sv
package io_pack_pkg;
   typedef enum logic [2:0] {MODE_STD, MODE_U1, MODE_U2, MODE_U3, MODE_ENH} mode_t;

   typedef struct packed {
      logic [4:0] div_cnt;
      logic sys_tick;
      logic [3:0][14:0] step_cnt;
      logic [3:0] step_stb;
      mode_t mode;
      logic [1:0] bank;
      logic [3:0] wmask;
      logic [7:0] pol;
      logic [3:0] db_ctl;
      logic [7:0] db_dur;
      logic dbclk_en;
      logic [31:0] arm;
      logic [31:0] flags;
      logic [31:0] prev;
      logic [7:0] ivr;
      logic ier_en;
      logic [15:0] rdata;
      logic ack_n;
      logic int_req_n;
   } host_state_t;

   typedef struct packed {
      logic level;
      logic [1:0] cnt;
   } debounce_state_t;
endpackage : io_pack_pkg

// file: rtl/input_debounce.sv
`timescale 1ns/100ps
`include "io_pack_regs.svh"
module input_debounce (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // control
   input wire logic enable,
   input wire logic sample,
   // line
   input wire logic raw,
   output logic level
);
   import io_pack_pkg::*;

   debounce_state_t r;
   debounce_state_t n;

   always_comb begin
      n = r;
      if (!enable) begin
         n.level = raw;
         n.cnt = '0;
      end else if (sample) begin
         if (raw == r.level) begin
            n.cnt = '0;
         end else if (r.cnt == `DB_STABLE) begin
            n.level = raw;  // [R11]
            n.cnt = '0;
         end else begin
            n.cnt = r.cnt + 2'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign level = r.level;

   // level moves only on a sample step while filtering
   level_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R9] [R10]
      (enable && !sample) |=> $stable(level))
      else $error("debounced level moved without a sample step");
endmodule : input_debounce

// file: rtl/identification_rom.sv
`timescale 1ns/100ps
`include "io_pack_regs.svh"
module identification_rom #(
   // arbitrary neutral identity values
   parameter logic [7:0] MAKER_ID = 8'h5A,
   parameter logic [7:0] MODEL_ID = 8'h3C,
   parameter logic [7:0] REV_ID = 8'h01
) (
   // lookup
   input wire logic [4:0] index,
   output logic [7:0] data
);
   always_comb begin
      case (index)  // [R4]
         `ID_OFS_I: data = `ID_ASCII_I;
         `ID_OFS_P: data = `ID_ASCII_P;
         `ID_OFS_A: data = `ID_ASCII_A;
         `ID_OFS_C: data = `ID_ASCII_C;
         `ID_OFS_MAKER: data = MAKER_ID;
         `ID_OFS_MODEL: data = MODEL_ID;
         `ID_OFS_REV: data = REV_ID;
         `ID_OFS_USED: data = `ID_USED_BYTES;
         default: data = 8'h00;
      endcase
   end
endmodule : identification_rom

// file: rtl/io_pack_host_interface.sv
`timescale 1ns/100ps
`include "io_pack_regs.svh"
module io_pack_host_interface #(
   parameter int DB_STEP0 = `DB_STEP0_NS * 1000 / `SYS_CLK_PERIOD_PS,
   parameter int DB_STEP1 = `DB_STEP1_NS * 1000 / `SYS_CLK_PERIOD_PS,
   parameter int DB_STEP2 = `DB_STEP2_NS * 1000 / `SYS_CLK_PERIOD_PS,
   parameter int DB_STEP3 = `DB_STEP3_NS * 1000 / `SYS_CLK_PERIOD_PS,
   parameter int CHANNELS = 32
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // carrier bus
   input wire logic io_sel_n,
   input wire logic id_sel_n,
   input wire logic int_sel_n,
   input wire logic mem_sel_n,
   input wire logic [5:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [15:0] rdata,
   output logic ack_n,
   // field inputs and interrupt
   input wire logic [CHANNELS-1:0] in_raw,
   output logic int_req_n
);
   import io_pack_pkg::*;

   // ----------------------------------------------------------------
   // constants
   // ----------------------------------------------------------------
   localparam int SYS_DIV = `SYS_CLK_PERIOD_PS / `MCLK_PERIOD_PS;
   localparam int STEP_DIV [4] = '{DB_STEP0, DB_STEP1, DB_STEP2, DB_STEP3};

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   host_state_t r;
   host_state_t n;
   logic io_cyc;
   logic id_cyc;
   logic int_cyc;
   logic io_wr;
   logic io_rd;
   logic [1:0] port;
   logic [4:0] lane;
   logic enh;

   // io wins over id, id over interrupt; memory space has no decode at all
   assign io_cyc = !io_sel_n;  // [R1]
   assign id_cyc = io_sel_n && !id_sel_n;
   assign int_cyc = io_sel_n && id_sel_n && !int_sel_n;
   assign io_wr = wr_stb && io_cyc;
   assign io_rd = rd_stb && io_cyc;
   assign port = addr[1:0];
   assign lane = {port, 3'b000};  // [R14]
   assign enh = (r.mode == MODE_ENH);

   // ----------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------
   logic [CHANNELS-1:0] lvl;
   logic [CHANNELS-1:0] hit;
   logic [7:0] id_byte;

   // only the 32 wired lines of the controller exist here  [R15]
   for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
      localparam int P = c / 8;
      logic stb;
      logic rise;
      logic fall;

      assign stb = r.step_stb[r.db_dur[2*P +: 2]];  // [R9]
      input_debounce u_db (
         .mclk(mclk),
         .rst_n(rst_n),
         .enable(r.db_ctl[P] && r.dbclk_en),  // [R10] [R11]
         .sample(stb),
         .raw(in_raw[c]),
         .level(lvl[c])
      );
      assign rise = lvl[c] && !r.prev[c];
      assign fall = !lvl[c] && r.prev[c];
      // polarity bit per group of four; high selects the falling edge
      assign hit[c] = r.arm[c] && (r.pol[c/4] ? fall : rise);  // [R12]
   end

   identification_rom u_rom (
      .index(addr[4:0]),
      .data(id_byte)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      n = r;
      n.ack_n = `ACK_IDLE;
      n.rdata = '0;

      // 8 MHz system tick and the four debounce sample steps
      n.sys_tick = 1'b0;
      if (r.div_cnt == 5'(SYS_DIV - 1)) begin
         n.div_cnt = '0;
         n.sys_tick = 1'b1;
      end else begin
         n.div_cnt = r.div_cnt + 5'h1;
      end
      for (int k = 0; k < 4; k++) begin
         n.step_stb[k] = 1'b0;
         if (r.sys_tick) begin
            if (r.step_cnt[k] == 15'(STEP_DIV[k] - 1)) begin
               n.step_cnt[k] = '0;
               n.step_stb[k] = 1'b1;  // [R9]
            end else begin
               n.step_cnt[k] = r.step_cnt[k] + 15'h1;
            end
         end
      end

      // event capture disarms the detector until rearmed
      n.prev = lvl;
      n.arm = r.arm & ~hit;

      // writes
      if (io_wr) begin
         if (r.mode != MODE_ENH && addr != `OFS_PORT7 && addr != `OFS_IVR
             && addr != `OFS_IER) begin
            n.mode = MODE_STD;
         end
         case (addr)
            `OFS_IVR: n.ivr = wdata[7:0];  // [R2] [R3]
            `OFS_IER: n.ier_en = wdata[`IER_EN_BIT];  // [R3]
            `OFS_PORT7: begin
               case (r.mode)  // [R16]
                  MODE_STD:
                     n.mode = (wdata[7:0] == `UNLOCK_B0) ? MODE_U1 : MODE_STD;
                  MODE_U1:
                     n.mode = (wdata[7:0] == `UNLOCK_B1) ? MODE_U2 : MODE_STD;
                  MODE_U2:
                     n.mode = (wdata[7:0] == `UNLOCK_B2) ? MODE_U3 : MODE_STD;
                  MODE_U3:
                     n.mode = (wdata[7:0] == `UNLOCK_B3) ? MODE_ENH : MODE_STD;
                  MODE_ENH: begin
                     n.bank = wdata[`BANK_LSB +: 2];  // [R17]
                     if (r.bank == `BANK_STATE) begin
                        n.wmask = wdata[3:0];
                     end
                  end
                  default: n.mode = MODE_STD;
               endcase
            end
            `OFS_PORT6: begin
               if (enh && r.bank == `BANK_EVENT) begin
                  n.pol = wdata[7:0];  // [R12]
               end
            end
            default: begin
               if (enh && addr[5:2] == 4'h0) begin
                  if (r.bank == `BANK_EVENT) begin
                     // a one arms; a zero drops the flag and leaves it disarmed
                     n.arm[lane +: 8] = wdata[7:0];  // [R18]
                     n.flags[lane +: 8] = r.flags[lane +: 8] & wdata[7:0];  // [R18] [R19]
                  end else if (r.bank == `BANK_DEBOUNCE) begin
                     case (addr)
                        `OFS_PORT0: n.db_ctl = wdata[3:0];
                        `OFS_PORT1: n.db_dur = wdata[7:0];
                        `OFS_PORT3: n.dbclk_en = wdata[`DBCLK_EN_BIT];  // [R10]
                        default: n.db_ctl = r.db_ctl;
                     endcase
                  end
               end
            end
         endcase
      end

      // a captured edge beats a clear in the same cycle
      n.flags = n.flags | hit;  // [R12]

      // controller reset from software keeps the vector; enable takes bit 0 of the same write
      if (io_wr && addr == `OFS_IER && wdata[`IER_SRST_BIT]) begin
         n.mode = MODE_STD;  // [R3]
         n.bank = `BANK_STATE;
         n.wmask = '0;
         n.pol = '0;
         n.db_ctl = '0;
         n.db_dur = '0;
         n.dbclk_en = 1'b0;
         n.arm = '0;
         n.flags = '0;
      end

      // reads: byte lane only, upper lane stays zero
      if (io_rd) begin
         case (addr)  // [R5] [R6]
            `OFS_IVR: n.rdata[7:0] = r.ivr;
            `OFS_IER: n.rdata[`IER_EN_BIT] = r.ier_en;
            `OFS_PORT7: n.rdata[7:0] = enh ? {r.bank, 2'b00, r.wmask} : 8'h00;
            default: begin
               if (addr[5:2] == 4'h0) begin
                  if (enh && r.bank == `BANK_EVENT) begin
                     n.rdata[7:0] = r.flags[lane +: 8];
                  end else if (enh && r.bank == `BANK_DEBOUNCE) begin
                     case (addr)
                        `OFS_PORT0: n.rdata[3:0] = r.db_ctl;
                        `OFS_PORT1: n.rdata[7:0] = r.db_dur;
                        `OFS_PORT3: n.rdata[`DBCLK_EN_BIT] = r.dbclk_en;
                        default: n.rdata = '0;
                     endcase
                  end else begin
                     n.rdata[7:0] = lvl[lane +: 8];  // [R14]
                  end
               end
            end
         endcase
      end else if (rd_stb && id_cyc) begin
         n.rdata[7:0] = id_byte;  // [R4]
      end else if (rd_stb && int_cyc) begin
         n.rdata[7:0] = r.ivr;  // [R7]
      end

      // one acknowledge the cycle after each io, id or interrupt strobe, never a wait
      if ((rd_stb || wr_stb) && (io_cyc || id_cyc || int_cyc)) begin
         n.ack_n = 1'b0;  // [R1] [R8] [R20]
      end

      n.int_req_n = !(r.ier_en && |r.flags);  // [R2] [R13] [R19]
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.ack_n <= `ACK_IDLE;
         r.int_req_n <= `IRQ_IDLE;
      end else begin
         r <= n;
      end
   end

   assign rdata = r.rdata;
   assign ack_n = r.ack_n;
   assign int_req_n = r.int_req_n;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // back-to-back strobes keep the acknowledge low for another cycle
   ack_timing_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R1] [R8]
      ((rd_stb || wr_stb) && !io_sel_n)
      |=> !ack_n ##1 (ack_n || $past(rd_stb || wr_stb)))
      else $error("io cycle not acknowledged in the next cycle");

   mem_ignore_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R20]
      ((rd_stb || wr_stb) && !mem_sel_n && io_sel_n && id_sel_n && int_sel_n)
      |=> ack_n)
      else $error("memory space cycle was acknowledged");

   upper_lane_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R5] [R6]
      rdata[15:8] == 8'h00)
      else $error("upper data byte not zero");

   vector_read_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R7]
      (rd_stb && int_cyc) |=> (rdata[7:0] == $past(r.ivr)) && !ack_n)
      else $error("interrupt select did not return the vector");

   irq_assert_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R13]
      (r.ier_en && |r.flags) |=> !int_req_n)
      else $error("enabled event did not raise the request");

   irq_release_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R19]
      (!r.ier_en || r.flags == '0) |=> int_req_n)
      else $error("request held without an enabled flag");

   bank_select_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R17]
      (io_wr && addr == `OFS_PORT7 && enh) |=> r.bank == $past(wdata[7:6]))
      else $error("bank not taken from bits 7:6");

   sw_reset_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R3]
      (io_wr && addr == `OFS_IER && wdata[`IER_SRST_BIT])
      |=> (r.mode == MODE_STD) && (r.ivr == $past(r.ivr)) && (r.flags == '0))
      else $error("software reset wrong or touched the vector");

   unlock_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R16]
      (io_wr && addr == `OFS_PORT7 && r.mode == MODE_U3 && wdata[7:0] == `UNLOCK_B3)
      |=> enh && r.bank == `BANK_STATE)
      else $error("unlock sequence did not enter enhanced mode");

   // a software reset in the same cycle overrides the capture, and an arm write overrides the disarm
   event_set_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R12] [R18]
      (|hit && !io_wr)
      |=> ((r.flags & $past(hit)) == $past(hit)) && ((r.arm & $past(hit)) == '0))
      else $error("captured event not flagged or still armed");

   id_read_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
      (rd_stb && id_cyc) |=> (rdata[7:0] == $past(id_byte)) && !ack_n)
      else $error("id space read did not return the rom byte");

   stray_ack_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R1] [R20]
      !(rd_stb || wr_stb) |=> ack_n)
      else $error("acknowledge without a strobe");

   read_idle_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R5] [R6]
      !rd_stb |=> (rdata == 16'h0000))
      else $error("read data not zero outside a read answer");

   raw_follow_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
      !r.dbclk_en |=> (lvl == $past(in_raw)))
      else $error("input level filtered without the debounce clock");

   int_write_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R7]
      (wr_stb && int_cyc) |=> (r.ivr == $past(r.ivr)))
      else $error("interrupt select write changed the vector");

   flag_clear_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R18] [R19]
      (io_wr && enh && r.bank == `BANK_EVENT && addr == `OFS_PORT0
       && wdata[7:0] == 8'h00 && hit[7:0] == 8'h00)
      |=> (r.flags[7:0] == 8'h00) && (r.arm[7:0] == 8'h00))
      else $error("zero write left a flag or an armed detector");

   pol_write_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
      (io_wr && enh && r.bank == `BANK_EVENT && addr == `OFS_PORT6)
      |=> (r.pol == $past(wdata[7:0])))
      else $error("polarity write not taken");
endmodule : io_pack_host_interface

// file: verification/carrier_model.sv
`timescale 1ns/100ps
module carrier_model (
   // clock
   input wire logic mclk,
   // selects and strobes
   output logic io_sel_n,
   output logic id_sel_n,
   output logic int_sel_n,
   output logic mem_sel_n,
   output logic wr_stb,
   output logic rd_stb,
   // address and data
   output logic [5:0] addr,
   output logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic ack_n
);
   initial begin
      {io_sel_n, id_sel_n, int_sel_n, mem_sel_n} = 4'hf;
      {wr_stb, rd_stb} = 2'b00;
      addr = 6'h00;
      wdata = 16'h0000;
   end

   // -------------------------------------------------------------
   // one zero-wait cycle: space 0 io, 1 id, 2 int, 3 mem
   // -------------------------------------------------------------
   task automatic bus_cycle(input int sp, input bit wr, input logic [5:0] a,
         input logic [7:0] d, output logic [15:0] rv, output logic acked);
      @(posedge mclk);
      io_sel_n <= (sp != 0);
      id_sel_n <= (sp != 1);
      int_sel_n <= (sp != 2);
      mem_sel_n <= (sp != 3);
      wr_stb <= wr;
      rd_stb <= !wr;
      addr <= a;
      wdata <= {~d, d};
      @(posedge mclk);
      {io_sel_n, id_sel_n, int_sel_n, mem_sel_n} <= 4'hf;
      {wr_stb, rd_stb} <= 2'b00;
      // released lines flip so a stale value cannot pass
      addr <= ~a;
      wdata <= {d, ~d};
      #1;
      // an unknown acknowledge stays unknown and fails the compare
      acked = ~ack_n;
      rv = rdata;
   endtask : bus_cycle
endmodule : carrier_model

// file: verification/io_pack_host_interface_tb_top.sv
`timescale 1ns/100ps
module io_pack_host_interface_tb_top;
   // -------------------------------------------------------------
   // signals and model state
   // -------------------------------------------------------------
   localparam int SP_IO = 0;
   localparam int SP_ID = 1;
   localparam int SP_INT = 2;
   localparam int SP_MEM = 3;
   localparam int TICK = 25;
   localparam int DB_STEP [4] = '{2, 3, 4, 5};
   logic mclk;
   logic resetn;
   logic io_sel_n, id_sel_n, int_sel_n, mem_sel_n, wr_stb, rd_stb, ack_n, int_req_n;
   logic [5:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [31:0] in_raw;
   logic [7:0] id_exp [12] = '{8'h49, 8'h50, 8'h41, 8'h43, 8'h5A, 8'h3C, 8'h01,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h0C};
   logic [1:0] m_bank = 2'h0;
   logic [3:0] m_mask = 4'h0;
   logic m_ier = 1'b0;
   logic [7:0] m_arm = 8'h00;
   logic [7:0] m_flags = 8'h00;
   logic [7:0] prev = 8'h00;
   logic [1:0] m_pol = 2'b00;
   int fails = 0;
   int num_checks = 0;

   io_pack_host_interface #(
      .DB_STEP0(DB_STEP[0]),
      .DB_STEP1(DB_STEP[1]),
      .DB_STEP2(DB_STEP[2]),
      .DB_STEP3(DB_STEP[3]),
      .CHANNELS(32)
   ) i_dut (
      .mclk(mclk),
      .resetn(resetn),
      .io_sel_n(io_sel_n),
      .id_sel_n(id_sel_n),
      .int_sel_n(int_sel_n),
      .mem_sel_n(mem_sel_n),
      .addr(addr),
      .wdata(wdata),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .rdata(rdata),
      .ack_n(ack_n),
      .in_raw(in_raw),
      .int_req_n(int_req_n)
   );

   carrier_model i_carrier (
      .mclk(mclk),
      .io_sel_n(io_sel_n),
      .id_sel_n(id_sel_n),
      .int_sel_n(int_sel_n),
      .mem_sel_n(mem_sel_n),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .addr(addr),
      .wdata(wdata),
      .rdata(rdata),
      .ack_n(ack_n)
   );

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // event model for port 0, edge seen one clock late like the design
   always @(posedge mclk) begin
      for (int c = 0; c < 8; c++) begin
         if (m_arm[c] && in_raw[c] !== prev[c] && in_raw[c] === !m_pol[c / 4]) begin
            m_flags[c] = 1'b1;
            m_arm[c] = 1'b0;
         end
      end
      prev = in_raw[7:0];
   end

   // -------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic give_verdict();
      if (fails == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   task automatic wr(input int sp, input logic [5:0] a, input logic [7:0] d);
      logic [15:0] rv;
      logic k;
      i_carrier.bus_cycle(sp, 1'b1, a, d, rv, k);
      check("write ack", {15'h0000, k}, {15'h0000, sp != SP_MEM});
      if (sp == SP_IO && a == 6'h09)
         m_ier = d[0];
      if (sp == SP_IO && a == 6'h00 && m_bank == 2'h1) begin
         m_arm = d;
         m_flags = m_flags & d;
      end
   endtask : wr

   task automatic rd(input int sp, input logic [5:0] a, input logic [7:0] e);
      logic [15:0] rv;
      logic k;
      i_carrier.bus_cycle(sp, 1'b0, a, 8'h00, rv, k);
      check("read ack", {15'h0000, k}, {15'h0000, sp != SP_MEM});
      check("read data", rv, {8'h00, e});
   endtask : rd

   task automatic p7(input logic [7:0] d);
      if (m_bank == 2'h0)
         m_mask = d[3:0];
      m_bank = d[7:6];
      wr(SP_IO, 6'h07, d);
      rd(SP_IO, 6'h07, {m_bank, 2'b00, m_mask});
   endtask : p7

   task automatic irq_chk();
      repeat (4) @(posedge mclk);
      #1;
      check("int_req_n", {15'h0000, int_req_n}, {15'h0000, !(m_ier && m_flags != 0)});
   endtask : irq_chk

   task automatic toggle(input int c);
      @(posedge mclk) in_raw[c] <= ~in_raw[c];
      irq_chk();
      rd(SP_IO, 6'h00, m_flags);
   endtask : toggle

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      logic [7:0] v;
      logic [7:0] lvl;
      int s;
      void'($urandom(60916));
      resetn = 1'b0;
      in_raw = 32'h0000_0000;
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      irq_chk();
      for (int i = 0; i < 32; i++)
         rd(SP_ID, 6'(i), (i < 12) ? id_exp[i] : 8'h00);
      wr(SP_ID, 6'h00, 8'hFF);
      rd(SP_ID, 6'h00, 8'h49);
      v = 8'($urandom);
      wr(SP_IO, 6'h08, v);
      wr(SP_MEM, 6'h08, ~v);
      wr(SP_INT, 6'h00, ~v);
      rd(SP_INT, 6'h00, v);
      rd(SP_IO, 6'h08, v);
      rd(SP_MEM, 6'h08, 8'h00);
      wr(SP_IO, 6'h09, 8'h03);
      rd(SP_IO, 6'h09, 8'h01);
      rd(SP_INT, 6'h00, v);
      wr(SP_IO, 6'h09, 8'h00);
      repeat (4) begin
         @(posedge mclk) in_raw <= $urandom;
         repeat (3) @(posedge mclk);
         for (int p = 0; p < 4; p++)
            rd(SP_IO, 6'(p), in_raw[8*p +: 8]);
         rd(SP_IO, 6'h07, 8'h00);
      end
      // a stray port write restarts the unlock count
      wr(SP_IO, 6'h07, 8'h07);
      wr(SP_IO, 6'h07, 8'h0D);
      wr(SP_IO, 6'h01, 8'h06);
      wr(SP_IO, 6'h07, 8'h06);
      wr(SP_IO, 6'h07, 8'h12);
      wr(SP_IO, 6'h07, 8'h05);
      rd(SP_IO, 6'h07, 8'h00);
      wr(SP_IO, 6'h07, 8'h07);
      wr(SP_IO, 6'h07, 8'h0D);
      wr(SP_IO, 6'h08, v);
      wr(SP_IO, 6'h07, 8'h06);
      wr(SP_IO, 6'h07, 8'h12);
      rd(SP_IO, 6'h07, 8'h00);
      p7(8'h05);
      p7(8'h7A);
      p7(8'h8F);
      p7(8'h40);
      // events: channels 0..3 rising, 4..7 falling
      @(posedge mclk) in_raw <= 32'h0000_00F0;
      wr(SP_IO, 6'h06, 8'h02);
      m_pol = 2'b10;
      wr(SP_IO, 6'h00, 8'hFF);
      wr(SP_IO, 6'h09, 8'h01);
      for (int c = 0; c < 8; c++)
         toggle(c);
      wr(SP_IO, 6'h00, 8'h00);
      irq_chk();
      toggle(5);
      toggle(5);
      wr(SP_IO, 6'h00, 8'h20);
      toggle(5);
      toggle(5);
      wr(SP_IO, 6'h09, 8'h00);
      irq_chk();
      rd(SP_IO, 6'h00, 8'h20);
      wr(SP_IO, 6'h00, 8'h00);
      // debounce on port 0 only; port 1 stays direct
      p7(8'h80);
      wr(SP_IO, 6'h03, 8'h01);
      wr(SP_IO, 6'h00, 8'h01);
      rd(SP_IO, 6'h03, 8'h01);
      for (int d = 0; d < 4; d++) begin
         s = DB_STEP[d] * TICK;
         p7(8'h80);
         wr(SP_IO, 6'h01, 8'(d));
         p7(8'h00);
         lvl = in_raw[7:0];
         // glitch shorter than one step must be swallowed
         @(posedge mclk) in_raw[3] <= ~in_raw[3];
         repeat (10) @(posedge mclk);
         in_raw[3] <= lvl[3];
         repeat (5 * s) @(posedge mclk);
         rd(SP_IO, 6'h00, lvl);
         @(posedge mclk) in_raw <= in_raw ^ 32'h0000_0108;
         repeat (3) @(posedge mclk);
         rd(SP_IO, 6'h01, in_raw[15:8]);
         repeat (3 * s - 20) @(posedge mclk);
         rd(SP_IO, 6'h00, lvl);
         repeat (s + 20) @(posedge mclk);
         rd(SP_IO, 6'h00, in_raw[7:0]);
      end
      // bus reset mid-run clears vector, enable and enhanced mode
      @(posedge mclk) resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(SP_IO, 6'h08, 8'h00);
      rd(SP_IO, 6'h09, 8'h00);
      rd(SP_IO, 6'h07, 8'h00);
      irq_chk();
      give_verdict();
   end

   // hang guard, well beyond the few thousand cycles the run needs
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      give_verdict();
   end
endmodule : io_pack_host_interface_tb_top
